// >>> rtl/cpam_bank.sv
// Summary of operation
// RULE1: each channel value is a float over two consecutive registers from its address.
// RULE2: read-only status word per channel; code zero means the value is good.
// RULE3: status code four reports a hardware fault on the channel.
// RULE4: one 16-bit alarm word per channel, four 4-bit groups, alarm one lowest.
// RULE5: lowest bit of each group shows the alarm active; read only.
// RULE6: second bit of each group shows acknowledge required; read only.
// RULE7: host writing one to a group's third bit acknowledges that alarm.
// RULE8: top bit of each group is spare and does nothing.
// RULE9: status code one for channel off, code six for overflow.
// RULE10: status code two for over range, code seven for bad value.
// RULE11: status code three for under range, code eight for no data.
// RULE12: status code five for a ranging error.
// RULE13: acknowledge clears acknowledge required; read-only and spare bits ignore writes.
`timescale 1ns/100ps
`default_nettype none
`include "cpam_regs.svh"

// ==========================================================
// host register bank for channels 9 to 11
module cpam_bank
	import cpam_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [15:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata,
	output logic o_reg_ack,
	output logic o_reg_err,
	input wire logic [CPAM_NUM_CH-1:0][31:0] i_process_value,
	input wire logic [CPAM_NUM_CH-1:0][`CPAM_COND_W-1:0] i_chan_cond,
	input wire logic [CPAM_NUM_CH-1:0][3:0] i_alarm_active,
	input wire logic [CPAM_NUM_CH-1:0][3:0] i_ack_req_set,
	output logic [CPAM_NUM_CH-1:0][3:0] o_alarm_ack
);

	// ==========================================================
	// address decode, shared by the read and write paths
	function automatic cpam_dec_type cpam_decode(input logic [15:0] addr);
		cpam_dec_type d;
		d.hit = 1'b1;
		d.ch = 2'h0;
		d.item = CPAM_IT_PV_HI;
		unique case (addr)
			`CPAM_CH9_PV_OFS: begin
				d.ch = 2'h0;
			end
			`CPAM_CH9_PV_OFS + `CPAM_PV_LO_STEP: begin
				d.ch = 2'h0;
				d.item = CPAM_IT_PV_LO; // see RULE1
			end
			`CPAM_CH9_STATUS_OFS: begin
				d.ch = 2'h0;
				d.item = CPAM_IT_STATUS;
			end
			`CPAM_CH9_ALARM_OFS: begin
				d.ch = 2'h0;
				d.item = CPAM_IT_ALARM;
			end
			`CPAM_CH10_PV_OFS: begin
				d.ch = 2'h1;
			end
			`CPAM_CH10_PV_OFS + `CPAM_PV_LO_STEP: begin
				d.ch = 2'h1;
				d.item = CPAM_IT_PV_LO; // see RULE1
			end
			`CPAM_CH10_STATUS_OFS: begin
				d.ch = 2'h1;
				d.item = CPAM_IT_STATUS;
			end
			`CPAM_CH10_ALARM_OFS: begin
				d.ch = 2'h1;
				d.item = CPAM_IT_ALARM;
			end
			`CPAM_CH11_PV_OFS: begin
				d.ch = 2'h2;
			end
			`CPAM_CH11_PV_OFS + `CPAM_PV_LO_STEP: begin
				d.ch = 2'h2;
				d.item = CPAM_IT_PV_LO; // see RULE1
			end
			`CPAM_CH11_STATUS_OFS: begin
				d.ch = 2'h2;
				d.item = CPAM_IT_STATUS;
			end
			`CPAM_CH11_ALARM_OFS: begin
				d.ch = 2'h2;
				d.item = CPAM_IT_ALARM;
			end
			default: begin
				d.hit = 1'b0;
			end
		endcase
		return d;
	endfunction : cpam_decode

	// ==========================================================
	// condition flags to status code, most severe cause first
	function automatic cpam_status_type cpam_status_of(input logic [`CPAM_COND_W-1:0] c);
		cpam_status_type s;
		if (c[`CPAM_COND_OFF]) begin
			s = CPAM_ST_OFF; // see RULE9
		end else if (c[`CPAM_COND_HWERR]) begin
			s = CPAM_ST_HWERR; // see RULE3
		end else if (c[`CPAM_COND_NODATA]) begin
			s = CPAM_ST_NODATA; // see RULE11
		end else if (c[`CPAM_COND_RANGERR]) begin
			s = CPAM_ST_RANGERR; // see RULE12
		end else if (c[`CPAM_COND_BADPV]) begin
			s = CPAM_ST_BADPV; // see RULE10
		end else if (c[`CPAM_COND_OVFL]) begin
			s = CPAM_ST_OVFL; // see RULE9
		end else if (c[`CPAM_COND_OVER]) begin
			s = CPAM_ST_OVER; // see RULE10
		end else if (c[`CPAM_COND_UNDER]) begin
			s = CPAM_ST_UNDER; // see RULE11
		end else begin
			s = CPAM_ST_GOOD; // see RULE2
		end
		return s;
	endfunction : cpam_status_of

	// ==========================================================
	// signals
	cpam_bank_state_type st_q;
	cpam_bank_state_type st_d;
	cpam_dec_type rd_dec;
	cpam_dec_type wr_dec;
	logic [CPAM_NUM_CH-1:0][15:0] alarm_word;
	logic [CPAM_NUM_CH-1:0][3:0] alarm_ack;

	assign rd_dec = cpam_decode(i_reg_addr);
	assign wr_dec = cpam_decode(i_reg_addr);

	// ==========================================================
	// one alarm word per channel
	cpam_alarm_if alm_if[CPAM_NUM_CH] ();

	for (genvar g = 0; g < CPAM_NUM_CH; g++) begin : g_alarm
		// write strobe only when the alarm word of this channel is hit
		assign alm_if[g].wr = i_reg_wr && wr_dec.hit && (wr_dec.item == CPAM_IT_ALARM)
			&& (wr_dec.ch == 2'(g)); // see RULE7
		assign alm_if[g].wdata = i_reg_wdata;
		assign alm_if[g].alarm_active = i_alarm_active[g];
		assign alm_if[g].ack_req_set = i_ack_req_set[g];
		assign alarm_word[g] = alm_if[g].word;
		assign alarm_ack[g] = alm_if[g].ack_pulse;

		cpam_alarm_word u_alarm (
			.i_clk(i_clk),
			.i_nrst(i_nrst),
			.alm(alm_if[g].chan)
		);
	end

	// ==========================================================
	// next state: sampling, read answer and access errors
	always_comb begin
		st_d = st_q;
		st_d.ack = 1'b0;
		st_d.err = 1'b0;
		// track live values and status every cycle
		for (int c = 0; c < CPAM_NUM_CH; c++) begin
			st_d.pv[c] = i_process_value[c];
			st_d.status[c] = cpam_status_of(i_chan_cond[c]); // see RULE2
		end
		if (i_reg_rd) begin
			st_d.ack = 1'b1;
			st_d.rdata = `CPAM_RST_WORD;
			if (!rd_dec.hit) begin
				st_d.err = 1'b1;
			end else begin
				unique case (rd_dec.item)
					CPAM_IT_PV_HI: begin
						// freeze the low half so both halves form one value
						st_d.rdata = st_q.pv[rd_dec.ch][31:16]; // see RULE1
						st_d.pv_lo_hold[rd_dec.ch] = st_q.pv[rd_dec.ch][15:0]; // see RULE1
					end
					CPAM_IT_PV_LO: begin
						st_d.rdata = st_q.pv_lo_hold[rd_dec.ch]; // see RULE1
					end
					CPAM_IT_STATUS: begin
						st_d.rdata = st_q.status[rd_dec.ch]; // see RULE2
					end
					CPAM_IT_ALARM: begin
						st_d.rdata = alarm_word[rd_dec.ch]; // see RULE4
					end
				endcase
			end
		end else if (i_reg_wr) begin
			// only the alarm word accepts writes; others answer with an error
			st_d.ack = 1'b1;
			st_d.err = !(wr_dec.hit && (wr_dec.item == CPAM_IT_ALARM)); // see RULE13
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// outputs, all from flip-flops
	assign o_reg_rdata = st_q.rdata;
	assign o_reg_ack = st_q.ack;
	assign o_reg_err = st_q.err;
	assign o_alarm_ack = alarm_ack;

endmodule : cpam_bank

`default_nettype wire

// >>> rtl/cpam_regs.svh
`ifndef CPAM_REGS_SVH
`define CPAM_REGS_SVH

// ==========================================================
// register addresses, 16-bit register index space
`define CPAM_CH9_PV_OFS 16'hf8e3
`define CPAM_CH9_STATUS_OFS 16'hf8e5
`define CPAM_CH9_ALARM_OFS 16'hf8e6
`define CPAM_CH10_PV_OFS 16'hf8e7
`define CPAM_CH10_STATUS_OFS 16'hf8e9
`define CPAM_CH10_ALARM_OFS 16'hf8ea
`define CPAM_CH11_PV_OFS 16'hf8eb
`define CPAM_CH11_STATUS_OFS 16'hf8ed
`define CPAM_CH11_ALARM_OFS 16'hf8ee

// ==========================================================
// value pair: high half at the value address, low half next
`define CPAM_PV_WORDS 2
`define CPAM_PV_LO_STEP 16'h0001

// ==========================================================
// channel condition input bit positions
`define CPAM_COND_OFF 0
`define CPAM_COND_OVER 1
`define CPAM_COND_UNDER 2
`define CPAM_COND_HWERR 3
`define CPAM_COND_RANGERR 4
`define CPAM_COND_OVFL 5
`define CPAM_COND_BADPV 6
`define CPAM_COND_NODATA 7
`define CPAM_COND_W 8

// ==========================================================
// alarm word layout: four groups of four bits
`define CPAM_ALM_NUM 4
`define CPAM_ALM_GRP_W 4
`define CPAM_ALM_ACTIVE_POS 0
`define CPAM_ALM_ACKREQ_POS 1
`define CPAM_ALM_ACKWR_POS 2
`define CPAM_ALM_SPARE_POS 3

// ==========================================================
// reset values
`define CPAM_RST_WORD 16'h0000
`define CPAM_RST_PV 32'h0000_0000

`endif

// >>> rtl/cpam_pkg.sv
package cpam_pkg;

	// ==========================================================
	// sizes
	localparam int CPAM_NUM_CH = 3;

	// ==========================================================
	// channel status word codes
	typedef enum logic [15:0] {
		CPAM_ST_GOOD = 16'h0000,
		CPAM_ST_OFF = 16'h0001,
		CPAM_ST_OVER = 16'h0002,
		CPAM_ST_UNDER = 16'h0003,
		CPAM_ST_HWERR = 16'h0004,
		CPAM_ST_RANGERR = 16'h0005,
		CPAM_ST_OVFL = 16'h0006,
		CPAM_ST_BADPV = 16'h0007,
		CPAM_ST_NODATA = 16'h0008
	} cpam_status_type;

	// ==========================================================
	// item selected by a register address
	typedef enum logic [1:0] {
		CPAM_IT_PV_HI = 2'h0,
		CPAM_IT_PV_LO = 2'h1,
		CPAM_IT_STATUS = 2'h2,
		CPAM_IT_ALARM = 2'h3
	} cpam_item_type;

	typedef struct packed {
		logic hit;
		logic [1:0] ch;
		cpam_item_type item;
	} cpam_dec_type;

	// ==========================================================
	// state of one channel's alarm word
	typedef struct packed {
		logic [3:0] active;
		logic [3:0] ack_req;
		logic [3:0] ack_pulse;
	} cpam_alarm_state_type;

	// ==========================================================
	// state of the register bank
	typedef struct packed {
		logic [15:0] rdata;
		logic ack;
		logic err;
		logic [CPAM_NUM_CH-1:0][31:0] pv;
		logic [CPAM_NUM_CH-1:0][15:0] pv_lo_hold;
		logic [CPAM_NUM_CH-1:0][15:0] status;
	} cpam_bank_state_type;

endpackage : cpam_pkg

// >>> rtl/cpam_alarm_if.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// link between the bank decoder and one channel's alarm word
interface cpam_alarm_if;
	logic [3:0] alarm_active;
	logic [3:0] ack_req_set;
	logic wr;
	logic [15:0] wdata;
	logic [15:0] word;
	logic [3:0] ack_pulse;

	modport bank (
		output alarm_active,
		output ack_req_set,
		output wr,
		output wdata,
		input word,
		input ack_pulse
	);

	modport chan (
		input alarm_active,
		input ack_req_set,
		input wr,
		input wdata,
		output word,
		output ack_pulse
	);
endinterface : cpam_alarm_if

`default_nettype wire

// >>> rtl/cpam_alarm_word.sv
`timescale 1ns/100ps
`default_nettype none
`include "cpam_regs.svh"

// ==========================================================
// one channel's 16-bit alarm word
module cpam_alarm_word
	import cpam_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	cpam_alarm_if.chan alm
);

	cpam_alarm_state_type st_q;
	cpam_alarm_state_type st_d;
	logic [3:0] ack_wr;

	// pick the write-one acknowledge bits out of the written word
	always_comb begin
		for (int a = 0; a < `CPAM_ALM_NUM; a++) begin
			ack_wr[a] = alm.wr && alm.wdata[a * `CPAM_ALM_GRP_W + `CPAM_ALM_ACKWR_POS]; // see RULE7
		end
	end

	// next state: the set of ack required wins over a same-cycle ack
	always_comb begin
		st_d = st_q;
		st_d.active = alm.alarm_active; // see RULE5
		st_d.ack_req = (st_q.ack_req & ~ack_wr) | alm.ack_req_set; // see RULE13
		st_d.ack_pulse = ack_wr; // see RULE7
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// read view: ack and spare bits always read zero
	always_comb begin
		alm.word = `CPAM_RST_WORD; // spare bits stay zero, see RULE8
		for (int a = 0; a < `CPAM_ALM_NUM; a++) begin
			alm.word[a * `CPAM_ALM_GRP_W + `CPAM_ALM_ACTIVE_POS] = st_q.active[a]; // see RULE4
			alm.word[a * `CPAM_ALM_GRP_W + `CPAM_ALM_ACKREQ_POS] = st_q.ack_req[a]; // see RULE6
		end
	end
	// spare position is never assigned above, so writes to it are lost

	assign alm.ack_pulse = st_q.ack_pulse;

endmodule : cpam_alarm_word

`default_nettype wire

// >>> bench/cpam_bank_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "cpam_regs.svh"

// ==========================================================
// port-level checks of the register bank
module cpam_bank_sva
	import cpam_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [15:0] i_reg_addr,
	input wire logic [15:0] i_reg_wdata,
	input wire logic [15:0] o_reg_rdata,
	input wire logic o_reg_ack,
	input wire logic o_reg_err,
	input wire logic [CPAM_NUM_CH-1:0][31:0] i_process_value,
	input wire logic [CPAM_NUM_CH-1:0][`CPAM_COND_W-1:0] i_chan_cond,
	input wire logic [CPAM_NUM_CH-1:0][3:0] i_alarm_active,
	input wire logic [CPAM_NUM_CH-1:0][3:0] i_ack_req_set,
	input wire logic [CPAM_NUM_CH-1:0][3:0] o_alarm_ack
);
	// request classes
	logic alm_a;
	logic wr_only;
	assign alm_a = i_reg_addr == `CPAM_CH9_ALARM_OFS || i_reg_addr == `CPAM_CH10_ALARM_OFS
		|| i_reg_addr == `CPAM_CH11_ALARM_OFS;
	assign wr_only = i_reg_wr && !i_reg_rd;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	AST_ACK_ONE: assert property ((i_reg_rd || i_reg_wr) |=> o_reg_ack)
		else $error("answer missing");
	AST_ACK_CAUSE: assert property (o_reg_ack |-> $past(i_reg_rd || i_reg_wr))
		else $error("answer without request");
	AST_WR_REFUSE: assert property (wr_only && !alm_a |=> o_reg_err)
		else $error("write to read-only place accepted");
	AST_ALM_WR_OK: assert property (wr_only && alm_a |=> !o_reg_err)
		else $error("alarm write refused");
	AST_ACK_PULSE9: assert property (wr_only && i_reg_addr == `CPAM_CH9_ALARM_OFS
		|=> o_alarm_ack[0] == {$past(i_reg_wdata[14]), $past(i_reg_wdata[10]),
		$past(i_reg_wdata[6]), $past(i_reg_wdata[2])}) else $error("ack pulse wrong");
	AST_ACK_SRC: assert property (o_alarm_ack != 12'h000 |-> $past(wr_only && alm_a))
		else $error("ack pulse without write");
	AST_SPARE_ZERO: assert property (i_reg_rd && alm_a
		|=> (o_reg_rdata & 16'hcccc) == 16'h0000) else $error("spare or ack bit reads one");
	AST_ACTIVE9: assert property (i_reg_rd && i_reg_addr == `CPAM_CH9_ALARM_OFS
		&& $stable(i_alarm_active[0]) |=> {o_reg_rdata[12], o_reg_rdata[8], o_reg_rdata[4],
		o_reg_rdata[0]} == $past(i_alarm_active[0])) else $error("active bits wrong");
	AST_GOOD9: assert property (i_reg_rd && i_reg_addr == `CPAM_CH9_STATUS_OFS
		&& $stable(i_chan_cond[0]) && i_chan_cond[0] == 8'h00 |=> o_reg_rdata == 16'h0000)
		else $error("good status not zero");
endmodule : cpam_bank_sva

bind cpam_bank cpam_bank_sva u_sva (.*);

`default_nettype wire

// >>> bench/cpam_host.sv
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// remote host issuing single register accesses
module cpam_host (
	input wire logic i_clk,
	input wire logic [15:0] i_rdata,
	input wire logic i_ack,
	input wire logic i_err,
	output logic o_rd,
	output logic o_wr,
	output logic [15:0] o_addr,
	output logic [15:0] o_wdata
);
	// idle bus at time zero
	initial begin
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_addr = 16'h0000;
		o_wdata = 16'h0000;
	end

	// request stands for one edge, answer taken one edge later
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic e, output logic k);
		@(negedge i_clk);
		o_rd = !w;
		o_wr = w;
		o_addr = a;
		o_wdata = d;
		@(negedge i_clk);
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_addr = ~a; // released lines flip so stale values cannot pass
		o_wdata = ~d;
		q = i_rdata;
		e = i_err;
		k = i_ack;
	endtask : xfer
endmodule : cpam_host

`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "cpam_regs.svh"

// ==========================================================
// self-checking bench of the register bank
module tb;
	import cpam_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rd, wr, ack, err, e, k;
	logic [15:0] addr, wdata, rdata, q, w;
	logic [CPAM_NUM_CH-1:0][31:0] pv = '0;
	logic [CPAM_NUM_CH-1:0][7:0] cond = '0;
	logic [CPAM_NUM_CH-1:0][3:0] act = '0;
	logic [CPAM_NUM_CH-1:0][3:0] rset = '0;
	logic [CPAM_NUM_CH-1:0][3:0] aack;
	logic [3:0] req [3] = '{4'h0, 4'h0, 4'h0};
	int n_errors = 0;
	int cmp_count = 0;

	always #4 clk = ~clk;

	cpam_bank dut (.i_clk(clk), .i_nrst(rst_n), .i_reg_rd(rd), .i_reg_wr(wr),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_ack(ack),
		.o_reg_err(err), .i_process_value(pv), .i_chan_cond(cond), .i_alarm_active(act),
		.i_ack_req_set(rset), .o_alarm_ack(aack));
	cpam_host host (.i_clk(clk), .i_rdata(rdata), .i_ack(ack), .i_err(err), .o_rd(rd),
		.o_wr(wr), .o_addr(addr), .o_wdata(wdata));

	// ==========================================================
	// expectations
	function automatic logic [15:0] st_code(input logic [7:0] c);
		int pos [8] = '{0, 3, 7, 4, 6, 5, 1, 2};
		int code [8] = '{1, 4, 8, 5, 7, 6, 2, 3};
		for (int i = 0; i < 8; i++) if (c[pos[i]]) return 16'(code[i]);
		return 16'h0000;
	endfunction : st_code

	function automatic logic [15:0] alm(input logic [3:0] a, input logic [3:0] r);
		alm = 16'h0000;
		for (int i = 0; i < 4; i++) begin
			alm[4*i] = a[i];
			alm[4*i+1] = r[i];
		end
	endfunction : alm

	function automatic logic [3:0] ackb(input logic [15:0] v);
		return {v[14], v[10], v[6], v[2]};
	endfunction : ackb

	function automatic logic [15:0] adr(input int c, input int n);
		return `CPAM_CH9_PV_OFS + 16'(4 * c + n);
	endfunction : adr

	// ==========================================================
	// compare, access and verdict
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic acc(input logic wt, input logic [15:0] a, input logic [15:0] d);
		host.xfer(wt, a, d, q, e, k);
		chk({15'h0000, k}, 16'h0001);
	endtask : acc

	task automatic close_out;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	// watchdog
	initial begin
		#100000;
		n_errors++;
		close_out();
	end

	// main sequence
	initial begin
		void'($urandom(32'hc6cc));
		repeat (16) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		repeat (2) @(negedge clk);
		for (int c = 0; c < 3; c++) begin
			pv[c] = $urandom();
			acc(1'b0, adr(c, 0), 16'h0000);
			chk(q, pv[c][31:16]);
			acc(1'b1, adr(c, 0), 16'(~pv[c]));
			chk({15'h0000, e}, 16'h0001);
			acc(1'b0, adr(c, 1), 16'h0000);
			chk(q, pv[c][15:0]);
			for (int i = 0; i < 12; i++) begin
				cond[c] = (i < 8) ? 8'(1 << i) : ((i == 8) ? 8'h00 : 8'($urandom()));
				acc(i[0], adr(c, 2), 16'(i)); // odd passes are refused writes
				chk({15'h0000, e}, {15'h0000, i[0]});
				acc(1'b0, adr(c, 2), 16'h0000);
				chk(q, st_code(cond[c]));
			end
			for (int r = 0; r < 4; r++) begin
				act[c] = 4'($urandom());
				rset[c] = (r == 0) ? 4'hf : 4'($urandom());
				req[c] = req[c] | rset[c];
				@(negedge clk);
				rset[c] = 4'h0;
				acc(1'b0, adr(c, 3), 16'h0000);
				chk(q, alm(act[c], req[c]));
				w = (r == 0) ? 16'hffff : 16'($urandom());
				acc(1'b1, adr(c, 3), w);
				chk({15'h0000, e}, 16'h0000);
				chk({4'h0, aack}, 16'(ackb(w)) << (4 * c));
				req[c] = req[c] & ~ackb(w);
				acc(1'b0, adr(c, 3), 16'h0000);
				chk(q, alm(act[c], req[c]));
			end
		end
		// unmapped places on both sides of the bank
		for (int u = 0; u < 2; u++) begin
			acc(1'b0, u ? 16'hf8ef : 16'hf8e2, 16'h0000);
			chk({q[14:0], e}, 16'h0001);
			acc(1'b1, u ? 16'hf8ef : 16'hf8e2, 16'hffff);
			chk({15'h0000, e}, 16'h0001);
		end
		close_out();
	end
endmodule : tb

`default_nettype wire
